/* cwg_load.sv */
// power switch driver model on the generator pins
`timescale 1ns/1ns
module cwg_load (
  input  wire logic [3:0] i_pin,
  input  wire logic [3:0] i_active_high,
  output logic      [3:0] o_on
);
  // switch conducts while its pin sits at the active level
  assign o_on = ~(i_pin ^ i_active_high);
endmodule : cwg_load

/* cwg_pkg.sv */
// package for the wave generator input select and polarity stage
package cwg_pkg;
  // source select codes, in table order
  localparam int unsigned SRC_COUNT = 14;
  localparam int unsigned SEL_W     = 4;
  localparam logic [3:0] SEL_PIN   = 4'h0;
  localparam logic [3:0] SEL_CCP1  = 4'h1;
  localparam logic [3:0] SEL_CCP2  = 4'h2;
  localparam logic [3:0] SEL_PWM3  = 4'h3;
  localparam logic [3:0] SEL_PWM4  = 4'h4;
  localparam logic [3:0] SEL_PWM5  = 4'h5;
  localparam logic [3:0] SEL_PWM6  = 4'h6;
  localparam logic [3:0] SEL_NCO   = 4'h7;
  localparam logic [3:0] SEL_CMP1  = 4'h8;
  localparam logic [3:0] SEL_CMP2  = 4'h9;
  localparam logic [3:0] SEL_LC1   = 4'ha;
  localparam logic [3:0] SEL_LC2   = 4'hb;
  localparam logic [3:0] SEL_LC3   = 4'hc;
  localparam logic [3:0] SEL_LC4   = 4'hd;
  localparam logic [3:0] SEL_RESET = 4'h0;
  // second control register polarity field, output a in bit 0, d in bit 3
  localparam int unsigned OUT_COUNT = 4;
  localparam int unsigned POL_LSB   = 0;
  localparam logic [3:0]  POL_RESET = 4'h0;
  // per-output internal drive bundle
  typedef struct packed {
    logic [3:0] wave;      // active-high after steering and dead band
    logic [3:0] ovr_en;    // output overridden
    logic [3:0] ovr_lvl;   // override level
  } cwg_drive_t;
endpackage : cwg_pkg

/* cwg_pol_stage.sv */
// per-output polarity and override stage
`timescale 1ns/1ns
module cwg_pol_stage
  import cwg_pkg::*;
#(
  parameter int unsigned N = OUT_COUNT
) (
  input  wire logic [N-1:0] i_wave,
  input  wire logic [N-1:0] i_pol,
  input  wire logic [N-1:0] i_ovr_en,
  input  wire logic [N-1:0] i_ovr_lvl,
  output logic      [N-1:0] o_pin
);
  // one lane per output
  for (genvar k = 0; k < N; k++) begin : g_lane
    // invert by xor with inverse polarity, override bypasses it
    assign o_pin[k] = i_ovr_en[k] ? i_ovr_lvl[k] : (i_wave[k] ^ ~i_pol[k]);
  end
endmodule : cwg_pol_stage

/* cwg_top.sv */
// wave generator drive source select and output polarity stage
// How it works
// - drive comes from one selectable source of fourteen internal or pin signals
// - software-written source select register chooses the drive source
// - every output has its own independent polarity bit
// - polarity one makes the output active high
// - polarity zero makes the output active low
// - override level goes out unchanged, never inverted by polarity
// - shutdown and steering are independent of polarity
// - polarity bits live in the second control register, one per output
// - four outputs a to d, polarity bits 3..0, d highest
`timescale 1ns/1ns
module cwg_top
  import cwg_pkg::*;
(
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic             i_drive_pin,     // remappable pin, asynchronous
  input  wire logic [SRC_COUNT-2:0] i_src,       // internal sources, codes 1..13
  input  wire logic             i_sel_we,
  input  wire logic [SEL_W-1:0] i_sel_data,
  input  wire logic             i_ctl2_we,
  input  wire logic [3:0]       i_ctl2_data,
  input  wire logic [3:0]       i_wave,          // steered, dead-banded, active high
  input  wire logic [3:0]       i_ovr_en,
  input  wire logic [3:0]       i_ovr_lvl,
  output logic                  o_drive,
  output logic [SEL_W-1:0]      o_sel,
  output logic [3:0]            o_pol,
  output logic [3:0]            o_pin
);
  // whole module state: synchroniser, settings and registered outputs
  typedef struct packed {
    logic [1:0]       pin_sync;
    logic [SEL_W-1:0] sel;
    logic [3:0]       pol;
    logic             drive;
    logic [3:0]       pin;
  } cwg_state_t;

  // state, next state and the combinational paths into it
  cwg_state_t st;
  cwg_state_t next_st;
  logic [SRC_COUNT-1:0] srcs;
  logic [3:0]           pin_comb;
  cwg_drive_t           drv;

  // source vector in code order: code 0 is the synced pin
  assign srcs = {i_src, st.pin_sync[1]};
  assign drv  = '{wave: i_wave, ovr_en: i_ovr_en, ovr_lvl: i_ovr_lvl};

  // polarity applied only at the pin, steering inputs untouched
  // override bypasses polarity inside each lane, so programmed levels go out as written
  cwg_pol_stage #(.N(OUT_COUNT)) u_pol (
    .i_wave    (drv.wave),
    .i_pol     (st.pol),
    .i_ovr_en  (drv.ovr_en),
    .i_ovr_lvl (drv.ovr_lvl),
    .o_pin     (pin_comb)
  );

  // next state
  always_comb begin
    next_st = st;
    // two-flop synchroniser, only the second stage is read
    next_st.pin_sync = {st.pin_sync[0], i_drive_pin};
    // software writes land on the strobe edge
    if (i_sel_we) begin
      next_st.sel = i_sel_data;
    end
    // polarity field, output a in the lowest bit
    if (i_ctl2_we) begin
      next_st.pol = i_ctl2_data[POL_LSB +: OUT_COUNT];
    end
    // a select change reaches o_drive one edge later; the pin adds two sync stages
    // unused codes select nothing
    next_st.drive = (st.sel < SEL_W'(SRC_COUNT)) ? srcs[st.sel] : 1'b0;
    // pins registered so each output leaves a flip-flop
    next_st.pin = pin_comb;
  end

  // state register
  // async clear: select code 0, every polarity active low
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{pin_sync: 2'h0, sel: SEL_RESET, pol: POL_RESET, drive: 1'b0, pin: 4'h0};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign o_drive = st.drive;
  assign o_sel   = st.sel;
  assign o_pol   = st.pol;
  assign o_pin   = st.pin;

  // assertions watch the registered outputs one edge after the inputs they follow;
  // the sampled reset in every antecedent but the two hold checks skips the release edge, where the flops still clear
  // a select write lands one edge after its strobe
  property p_sel_write;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_rst_n && i_sel_we) |=> (o_sel == $past(i_sel_data));
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select write lost");

  // code 1 routes the first internal source
  property p_drive_src;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_rst_n && o_sel == SEL_CCP1 && !i_sel_we) |=> (o_drive == $past(i_src[0]));
  endproperty
  a_drive_src: assert property (p_drive_src) else $error("wrong drive source");

  // a polarity write lands one edge after its strobe
  property p_pol_write;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_rst_n && i_ctl2_we) |=> (o_pol == $past(i_ctl2_data));
  endproperty
  a_pol_write: assert property (p_pol_write) else $error("polarity write lost");

  // output d set active high follows its wave
  property p_active_high;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_rst_n && o_pol[3] && !i_ovr_en[3] && !i_ctl2_we) |=> (o_pin[3] == $past(i_wave[3]));
  endproperty
  a_active_high: assert property (p_active_high) else $error("active high wrong");

  // output a set active low shows the inverse of its wave
  property p_active_low;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_rst_n && !o_pol[0] && !i_ovr_en[0] && !i_ctl2_we) |=> (o_pin[0] == !$past(i_wave[0]));
  endproperty
  a_active_low: assert property (p_active_low) else $error("active low wrong");

  // an overridden output carries its level uninverted
  property p_override;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_rst_n && i_ovr_en[1]) |=> (o_pin[1] == $past(i_ovr_lvl[1]));
  endproperty
  a_override: assert property (p_override) else $error("override inverted");

  // outputs a and b use their own bits: same wave, different polarity, different pins
  property p_independent;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_rst_n && !i_ovr_en[1] && !i_ovr_en[0] && i_wave[1] == i_wave[0] && o_pol[1] != o_pol[0])
        |=> (o_pin[1] != o_pin[0]);
  endproperty
  a_independent: assert property (p_independent) else $error("polarity bit disturbed");

  // output c: one register stage from wave and polarity to the pin
  property p_pin_latency;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_rst_n && !i_ovr_en[2] && !i_ctl2_we) |=> (o_pin[2] == ($past(i_wave[2]) ^ ~o_pol[2]));
  endproperty
  a_pin_latency: assert property (p_pin_latency) else $error("pin mismatch");

  // code 0: three quiet cycles let the synced pin level reach the drive
  sequence s_pin_steady;
    (i_rst_n && o_sel == SEL_PIN && !i_sel_we) [*3];
  endsequence

  property p_pin_source;
    @(posedge i_clock) disable iff (!i_rst_n)
      s_pin_steady |=> (o_drive == $past(i_drive_pin, 3));
  endproperty
  a_pin_source: assert property (p_pin_source) else $error("pin source wrong");

  // codes 1 to 13: each internal source reaches the drive one edge after it is seen
  for (genvar c = 1; c < SRC_COUNT; c++) begin : g_src_chk
    property p_src_route;
      @(posedge i_clock) disable iff (!i_rst_n)
        (i_rst_n && o_sel == SEL_W'(c)) |=> (o_drive == $past(i_src[c-1]));
    endproperty
    a_src_route: assert property (p_src_route) else $error("internal source misrouted");
  end

  // codes with no source behind them hold the drive low
  property p_unused_code;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_rst_n && o_sel >= SEL_W'(SRC_COUNT)) |=> !o_drive;
  endproperty
  a_unused_code: assert property (p_unused_code) else $error("unused code drives");

  // without a write strobe both settings stay put
  property p_sel_hold;
    @(posedge i_clock) disable iff (!i_rst_n) !i_sel_we |=> $stable(o_sel);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select changed unwritten");

  property p_pol_hold;
    @(posedge i_clock) disable iff (!i_rst_n) !i_ctl2_we |=> $stable(o_pol);
  endproperty
  a_pol_hold: assert property (p_pol_hold) else $error("polarity changed unwritten");

  // every lane on its own bit: override level as is, else wave matched to polarity
  for (genvar k = 0; k < OUT_COUNT; k++) begin : g_lane_chk
    property p_lane_pin;
      @(posedge i_clock) disable iff (!i_rst_n)
        (i_rst_n && !i_ctl2_we) |=> (o_pin[k] == ($past(i_ovr_en[k]) ? $past(i_ovr_lvl[k])
                                                                      : ($past(i_wave[k]) == o_pol[k])));
    endproperty
    a_lane_pin: assert property (p_lane_pin) else $error("lane pin wrong");
  end

  // select write then source: the new source drives two edges after the write
  sequence s_sel_load;
    (i_rst_n && i_sel_we && i_sel_data == SEL_CCP2) ##1 1'b1;
  endsequence

  property p_sel_load;
    @(posedge i_clock) disable iff (!i_rst_n)
      s_sel_load |=> (o_drive == $past(i_src[1]));
  endproperty
  a_sel_load: assert property (p_sel_load) else $error("select load late");

  // polarity write then settle: output d shows the new polarity two edges after the write
  sequence s_pol_load;
    (i_rst_n && i_ctl2_we) ##1 !i_ovr_en[3];
  endsequence

  property p_pol_load;
    @(posedge i_clock) disable iff (!i_rst_n)
      s_pol_load |=> (o_pin[3] == ($past(i_wave[3]) == $past(i_ctl2_data[3], 2)));
  endproperty
  a_pol_load: assert property (p_pol_load) else $error("polarity load late");
endmodule : cwg_top

/* cwg_top_tb.sv */
// self-checking bench for source select and output polarity
`timescale 1ns/1ns
module cwg_top_tb;
  import cwg_pkg::*;
  // rows: polarity, wave, override enable, override level, expected pins
  typedef struct packed {logic [3:0] pol, wave, oen, olvl, pin;} cwg_row_t;
  localparam cwg_row_t ROWS [4] = '{'{4'hf, 4'h5, 4'h0, 4'h0, 4'h5}, '{4'h0, 4'h5, 4'h0, 4'h0, 4'ha},
                                    '{4'ha, 4'h3, 4'h0, 4'h0, 4'h6}, '{4'h5, 4'h6, 4'hc, 4'ha, 4'h8}};
  logic        i_clock = 0, i_rst_n = 0, i_drive_pin = 0, i_sel_we = 0, i_ctl2_we = 0;
  logic [12:0] i_src = 13'h0;
  logic [3:0]  i_sel_data = 4'h0, i_ctl2_data = 4'h0, i_wave = 4'h0, i_ovr_en = 4'h0, i_ovr_lvl = 4'h0;
  logic        o_drive, exp_drive;
  logic [3:0]  o_sel, o_pol, o_pin, on;
  cwg_row_t    r;
  int          mismatches = 0, checks_done = 0;
  cwg_top dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_drive_pin(i_drive_pin), .i_src(i_src),
    .i_sel_we(i_sel_we), .i_sel_data(i_sel_data), .i_ctl2_we(i_ctl2_we), .i_ctl2_data(i_ctl2_data),
    .i_wave(i_wave), .i_ovr_en(i_ovr_en), .i_ovr_lvl(i_ovr_lvl), .o_drive(o_drive), .o_sel(o_sel),
    .o_pol(o_pol), .o_pin(o_pin));
  cwg_load load (.i_pin(o_pin), .i_active_high(o_pol), .o_on(on));
  // 10 MHz clock
  always #50 i_clock = ~i_clock;
  // compare and count
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // watchdog
  initial begin
    #40000;
    mismatches++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge i_clock);
    #1;
    chk(o_pin, 4'h0);
    chk(o_pol, 4'h0);
    chk(o_sel, 4'h0);
    chk({3'h0, o_drive}, 4'h0);
    @(posedge i_clock) i_rst_n <= 1;
    // first edge after release: inputs low, active low pins go high
    @(posedge i_clock) #1 chk(o_pin, 4'hf);
    // every select code, rows cycled for polarity and override
    for (int i = 0; i < 16; i++) begin
      r = ROWS[i % 4];
      @(posedge i_clock);
      i_sel_we <= 1;
      i_sel_data <= 4'(i);
      i_ctl2_we <= 1;
      i_ctl2_data <= r.pol;
      {i_wave, i_ovr_en, i_ovr_lvl} <= {r.wave, r.oen, r.olvl};
      i_src <= (i % 2) ? ~(13'h1 << (i - 1)) : (13'h1 << (i - 1));
      i_drive_pin <= (i % 2 == 0);
      @(posedge i_clock);
      i_sel_we <= 0;
      i_ctl2_we <= 0;
      repeat (4) @(posedge i_clock);
      #1;
      exp_drive = (i < 14) && (i % 2 == 0);
      chk({3'h0, o_drive}, {3'h0, exp_drive});
      chk(o_sel, 4'(i));
      chk(o_pol, r.pol);
      chk(o_pin, r.pin);
      chk(on & ~r.oen, r.wave & ~r.oen);
    end
    // back-to-back polarity writes, one edge to show
    @(posedge i_clock) {i_ctl2_we, i_ctl2_data} <= 5'h11;
    @(posedge i_clock) i_ctl2_data <= 4'h8;
    #1 chk(o_pol, 4'h1);
    @(posedge i_clock) i_ctl2_we <= 0;
    #1 chk(o_pol, 4'h8);
    // reset in mid-run clears select and polarity
    @(posedge i_clock) i_rst_n <= 0;
    #1 chk(o_pol | o_sel, 4'h0);
    chk(o_pin | {3'h0, o_drive}, 4'h0);
    @(posedge i_clock) i_rst_n <= 1;
    // first edge after release: polarity low again, overrides still on c and d
    @(posedge i_clock) #1 chk(o_pin, 4'h9);
    chk(o_pol | o_sel, 4'h0);
    // a polarity write after release reaches the pins two edges on
    @(posedge i_clock) {i_ctl2_we, i_ctl2_data} <= 5'h1f;
    @(posedge i_clock) i_ctl2_we <= 0;
    @(posedge i_clock) #1 chk(o_pin, 4'ha);
    end_sim();
  end
endmodule : cwg_top_tb
